// [shared/hrp_mem_if.sv]
// Interface between port control and its register memory
`timescale 1ns/1ps
interface hrp_mem_if;
    import hrp_pkg::*;
    logic we;
    logic [HRP_ADDR_W-1:0] waddr;
    logic [HRP_DATA_W-1:0] wdata;
    logic re;
    logic [HRP_ADDR_W-1:0] raddr;
    logic [HRP_DATA_W-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface : hrp_mem_if

// [shared/hrp_pkg.sv]
// Package with constants and types for the hard core reconfiguration port
package hrp_pkg;
    // Bus geometry
    localparam int HRP_ADDR_W = 10;
    localparam int HRP_DATA_W = 16;
    localparam int HRP_BE_W = 2;
    localparam int HRP_DEPTH = 1024;
    // Read latency: data valid on third cycle after strobe
    localparam int HRP_RD_LAT = 3;
    localparam logic [1:0] HRP_LAT_LAST = 2'h2;
    localparam logic [1:0] HRP_LAT_ZERO = 2'h0;
    localparam logic [1:0] HRP_LAT_ONE = 2'h1;
    // Default value of every reconfiguration register
    localparam logic [15:0] HRP_REG_DEFAULT = 16'h0000;
    localparam logic [15:0] HRP_DATA_ZERO = 16'h0000;
    localparam logic [9:0] HRP_ADDR_ZERO = 10'h000;
    localparam logic [9:0] HRP_ADDR_ONE = 10'h001;
    localparam logic [9:0] HRP_ADDR_LAST = 10'h3FF;
    // Read pipeline states
    typedef enum logic [1:0] {HRP_IDLE, HRP_WAIT, HRP_DONE} hrp_rd_state_t;
endpackage : hrp_pkg

// [sim/hrp_master_model.sv]
// Application-side master model: enable sequence and selector control
`timescale 1ns/1ps
module hrp_master_model (
    // Clock
    input wire logic clk,
    // Bench requests
    input wire logic start,
    input wire logic access,
    // Enable sequence outputs
    output logic ser_shift_load,
    output logic interface_sel
);
    int cnt; // Cycles since the sequence began
    logic seq_r; // Sequence in progress
    initial begin
        ser_shift_load = 1'b0;
        seq_r = 1'b0;
        cnt = 0;
    end
    // One strobe pulse; 33 cycles covers the 324 ns minimum at 10 ns
    always @(posedge clk) begin
        if (start && !seq_r) begin
            seq_r <= 1'b1;
            cnt <= 0;
            ser_shift_load <= 1'b1;
        end else if (seq_r) begin
            cnt <= cnt + 1;
            if (cnt == 32) ser_shift_load <= 1'b0;
            if (cnt == 36) seq_r <= 1'b0;
        end
    end
    // Selector stays up through the sequence and every access
    assign interface_sel = seq_r | access;
endmodule : hrp_master_model

// [sim/tb_hrp_port.sv]
// Self-checking bench for the reconfiguration port
`timescale 1ns/1ps
module tb_hrp_port;
    import hrp_pkg::*;
    typedef struct {logic [9:0] a; logic [15:0] d; logic [1:0] be;} hrp_row_t;
    logic clk, ce, rst_n, read, write, start, access, ser_shift_load, interface_sel;
    logic restore_busy, readdata_valid;
    logic [9:0] address;
    logic [15:0] writedata, readdata, last_write_data;
    logic [1:0] byte_en;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // Edge and alternating-bit addresses and every byte-enable code
    hrp_row_t rows[4] = '{'{10'h000, 16'hA5A5, 2'h0}, '{10'h3FF, 16'h5A5A, 2'h1},
        '{10'h155, 16'hFFFF, 2'h2}, '{10'h2AA, 16'h0001, 2'h3}};
    hrp_port dut (.clk(clk), .ce(ce), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byte_en(byte_en), .readdata(readdata), .ser_shift_load(ser_shift_load),
        .interface_sel(interface_sel), .restore_busy(restore_busy), .readdata_valid(readdata_valid),
        .last_write_data(last_write_data));
    hrp_master_model mdl (.clk(clk), .start(start), .access(access), .ser_shift_load(ser_shift_load),
        .interface_sel(interface_sel));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk; // 100 MHz, inside the allowed band
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk) begin write <= 1'b1; address <= a; writedata <= d; byte_en <= be; end
        @(posedge clk) write <= 1'b0;
        #1;
    endtask : wr
    // Result is looked at just after the third edge past the taking edge
    task automatic rd(input logic [9:0] a, input logic [15:0] exp);
        @(posedge clk) begin read <= 1'b1; address <= a; end
        @(posedge clk) read <= 1'b0;
        repeat (3) @(posedge clk); // no new read before the result
        #1 chk({15'h0, readdata_valid}, 16'h0001, "valid");
        chk(readdata, exp, "readdata");
    endtask : rd
    task automatic do_reset();
        @(posedge clk) rst_n <= 1'b0;
        repeat (11) @(posedge clk);
        #1 chk({15'h0, restore_busy}, 16'h0001, "busy in reset");
        chk(readdata, HRP_DATA_ZERO, "readdata in reset");
        chk(last_write_data, HRP_REG_DEFAULT, "last write in reset");
        @(posedge clk) rst_n <= 1'b1;
        for (int i = 0; i < 1100 && restore_busy !== 1'b0; i++) @(posedge clk);
        #1 chk({15'h0, restore_busy}, 16'h0000, "busy end");
    endtask : do_reset
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        ce = 1'b1; rst_n = 1'b0; address = 10'h000; read = 1'b0; write = 1'b0;
        writedata = 16'h0000; byte_en = 2'h0; start = 1'b0; access = 1'b0;
        do_reset();
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        repeat (40) @(posedge clk);
        access <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(rows[i].a, rows[i].d, rows[i].be);
            chk(last_write_data, rows[i].d, "row write");
            rd(rows[i].a, rows[i].d);
        end
        $display("Test rows done");
        // Back-to-back writes, no wait states
        @(posedge clk) begin write <= 1'b1; address <= 10'h001; writedata <= 16'h1234; end
        @(posedge clk) begin address <= 10'h002; writedata <= 16'hBEEF; end
        @(posedge clk) write <= 1'b0;
        #1 chk(last_write_data, 16'hBEEF, "b2b last");
        rd(10'h001, 16'h1234);
        rd(10'h002, 16'hBEEF);
        $display("Test back-to-back done");
        // Selector low: write must be ignored
        @(posedge clk) access <= 1'b0;
        wr(10'h001, 16'h0F0F, 2'h3);
        chk(last_write_data, 16'hBEEF, "sel low write");
        @(posedge clk) access <= 1'b1;
        rd(10'h001, 16'h1234);
        $display("Test selector done");
        // Reset in mid-run restores defaults
        do_reset();
        rd(10'h3FF, HRP_REG_DEFAULT);
        rd(10'h001, HRP_REG_DEFAULT);
        $display("Test reset done");
        final_report();
    end
endmodule : tb_hrp_port

// [src/hrp_mem.sv]
// Register memory with registered read data
`timescale 1ns/1ps
module hrp_mem
    import hrp_pkg::*;
(
    // Clocking
    input wire logic clk,
    input wire logic ce,
    // Memory port
    hrp_mem_if.mem m
);
    // Storage array, one word per reconfiguration register
    logic [HRP_DATA_W-1:0] mem_r [HRP_DEPTH];
    logic [HRP_DATA_W-1:0] rdata_r;

    // Write port; reset clearing is done by the controller walking addresses
    always_ff @(posedge clk) begin
        if (ce && m.we) begin
            mem_r[m.waddr] <= m.wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        if (ce && m.re) begin
            rdata_r <= mem_r[m.raddr];
        end
    end

    assign m.rdata = rdata_r;
endmodule : hrp_mem

// [src/hrp_port.sv]
// Reconfiguration port slave: strobes, read latency, default restore
`timescale 1ns/1ps
module hrp_port
    import hrp_pkg::*;
(
    // Clock, enable and reset
    input wire logic clk,
    input wire logic ce,
    input wire logic rst_n,
    // Slave port
    input wire logic [HRP_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [HRP_DATA_W-1:0] writedata,
    input wire logic [HRP_BE_W-1:0] byte_en,
    output logic [HRP_DATA_W-1:0] readdata,
    // Enable sequence inputs
    input wire logic ser_shift_load,
    input wire logic interface_sel,
    // Status
    output logic restore_busy,
    output logic readdata_valid,
    // Configuration word view for the hard core
    output logic [HRP_DATA_W-1:0] last_write_data
);
    hrp_mem_if mif ();

    hrp_rd_state_t state_r; // Read pipeline state
    logic [1:0] lat_r; // Cycles since read strobe
    logic [HRP_ADDR_W-1:0] rst_addr_r; // Default restore walker
    logic busy_r; // Restore in progress
    logic [HRP_DATA_W-1:0] rdata_r; // Output read data
    logic valid_r; // Read data valid flag
    logic [HRP_DATA_W-1:0] lastw_r; // Last word accepted
    logic access_ok; // Strobes accepted only when selected and idle

    // Byte enables have no effect on writes
    logic be_unused;
    assign be_unused = ^byte_en;

    // Selector gates every access; the master keeps it high while working
    assign access_ok = interface_sel && !busy_r;

    // Memory has no reset, so a walker rewrites defaults after reset.
    // Trade-off: 1024 cycles busy instead of 16k flops with reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_addr_r <= HRP_ADDR_ZERO;
            busy_r <= 1'b1;
        end else if (ce && busy_r) begin
            if (rst_addr_r == HRP_ADDR_LAST) begin
                // Last word rewritten, accesses open again
                busy_r <= 1'b0;
            end else begin
                // Step to the next word
                rst_addr_r <= rst_addr_r + HRP_ADDR_ONE;
            end
        end
    end

    // Write acceptance, shared so memory and last-word register agree
    function automatic logic wr_take(input logic wr, input logic ok);
        return wr && ok;
    endfunction : wr_take

    // Write path: full word stored on the strobe edge, no wait states
    assign mif.we = busy_r ? 1'b1 : wr_take(write, access_ok);
    assign mif.waddr = busy_r ? rst_addr_r : address;
    assign mif.wdata = busy_r ? HRP_REG_DEFAULT : writedata;

    // Read path into memory
    assign mif.re = read && access_ok && (state_r == HRP_IDLE);
    assign mif.raddr = address;

    hrp_mem u_mem (
        .clk(clk),
        .ce(ce),
        .m(mif)
    );

    // Read pipeline: strobe, memory cycle, output register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= HRP_IDLE;
            lat_r <= HRP_LAT_ZERO;
        end else if (ce) begin
            case (state_r)
                HRP_IDLE: begin
                    // Overlapping reads are not accepted
                    if (mif.re) begin
                        state_r <= HRP_WAIT;
                        lat_r <= HRP_LAT_ONE;
                    end
                end
                HRP_WAIT: begin
                    // Count two edges; memory data holds since no new read is taken
                    lat_r <= lat_r + HRP_LAT_ONE;
                    if (lat_r == HRP_LAT_LAST) begin
                        state_r <= HRP_DONE;
                    end
                end
                HRP_DONE: begin
                    // Result goes out on this edge, the third after the strobe
                    state_r <= HRP_IDLE;
                    lat_r <= HRP_LAT_ZERO;
                end
                default: begin
                    // Unreachable; recover to idle
                    state_r <= HRP_IDLE;
                    lat_r <= HRP_LAT_ZERO;
                end
            endcase
        end
    end

    // Output data register loaded on the third edge after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= HRP_DATA_ZERO;
            valid_r <= 1'b0;
        end else if (ce) begin
            valid_r <= (state_r == HRP_DONE);
            if (state_r == HRP_DONE) begin
                rdata_r <= mif.rdata;
            end
        end
    end

    // Last accepted write, visible to the core logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lastw_r <= HRP_REG_DEFAULT;
        end else if (ce && wr_take(write, access_ok)) begin
            lastw_r <= writedata;
        end
    end

    assign readdata = rdata_r;
    assign readdata_valid = valid_r;
    assign restore_busy = busy_r;
    assign last_write_data = lastw_r;

    // Read data must show up exactly on the third cycle
    // Strobe edge of an accepted read
    sequence rd_start_s;
        mif.re && ce;
    endsequence
    // Three enabled edges, then the one-cycle result
    sequence rd_ret_s;
        ce [*3] ##1 valid_r;
    endsequence
    // Start-to-result timing, counted in enabled edges
    property rd_lat_p;
        @(posedge clk) disable iff (!rst_n) rd_start_s |=> rd_ret_s;
    endproperty
    read_latency_a: assert property (rd_lat_p) else $error("read data late");

    // A read in flight blocks the next strobe until the result edge
    no_overlap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mif.re && ce) |=> !mif.re [*3]) else $error("overlapping read accepted");

    // Accepted write lands on its own strobe edge
    wr_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        (write && access_ok && ce) |=> (lastw_r == $past(writedata))) else $error("write not stored");

    // Whole word goes to memory whatever the byte enables say
    wr_full_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mif.we && !busy_r) |-> (mif.wdata == writedata)) else $error("partial word write");

    // Walker writes only default words
    restore_default_a: assert property (@(posedge clk) disable iff (!rst_n)
        busy_r |-> (mif.we && mif.wdata == HRP_REG_DEFAULT)) else $error("default not restored");

    // Selector low shuts the port
    sel_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!interface_sel && !busy_r) |-> (!mif.re && !mif.we)) else $error("access without selector");

    // Returned word is the one the memory gave on the result edge
    rd_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        (valid_r && ce) |-> (readdata == $past(mif.rdata))) else $error("read data mismatch");

    // Restore ends right after the last address
    restore_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        (busy_r && ce && rst_addr_r == HRP_ADDR_LAST) |=> !busy_r) else $error("restore did not end");

    // Valid is a pulse of one enabled cycle; while ce is low it holds its level
    valid_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        (valid_r && ce) |=> !valid_r) else $error("read valid held too long");

    // No read is taken while defaults are still being rewritten
    busy_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        busy_r |-> !mif.re) else $error("read taken during restore");

    // Read data register only moves when a result is returned
    rd_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && state_r != HRP_DONE) |=> $stable(readdata)) else $error("read data moved early");

    // Write strobes reach the memory at once, never stalled
    wr_nowait_a: assert property (@(posedge clk) disable iff (!rst_n)
        (write && access_ok) |-> (mif.we && mif.waddr == address)) else $error("write stalled");

    // Walker address stays put once the restore is over
    walk_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy_r |=> $stable(rst_addr_r)) else $error("walker moved when idle");
endmodule : hrp_port
